// ==== logic/nand_per_lun_feature_regs.sv ====
// per-unit feature register bank behind host command/address/data cycles
// assumes host cycles and training inputs are in the core clock domain
`timescale 1ns/10ps
module nand_per_lun_feature_regs (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire nand_lun_feat_pkg::host_cycle_s i_cycle,
	input wire logic [15:0] i_line_status [nand_lun_feat_pkg::LUN_COUNT],
	input wire logic i_train_start,
	input wire logic [7:0] i_train_lun,
	output nand_lun_feat_pkg::lun_cfg_s o_cfg [nand_lun_feat_pkg::LUN_COUNT],
	output logic [7:0] o_rdata,
	output logic o_rdata_valid,
	output logic [1:0] o_train_go
);
	// ----------------------------------------
	// sequence state
	// ----------------------------------------
	nand_lun_feat_pkg::seq_state_e state; // access phase
	nand_lun_feat_pkg::seq_state_e next_state;
	logic is_set; // access writes parameters
	logic [7:0] lun_q; // latched unit selector
	logic [7:0] feat_q; // latched feature address
	logic [1:0] idx; // parameter byte index
	nand_lun_feat_pkg::lun_cfg_s cfg [nand_lun_feat_pkg::LUN_COUNT];
	logic [1:0] go_req; // per-unit training request

	// decode of the incoming cycle
	wire is_get_cmd = i_cycle.cmd && i_cycle.value == nand_lun_feat_pkg::CMD_GET_LUN;
	wire is_set_cmd = i_cycle.cmd && i_cycle.value == nand_lun_feat_pkg::CMD_SET_LUN;
	wire lun_ok = lun_q == nand_lun_feat_pkg::LUN0_SEL || lun_q == nand_lun_feat_pkg::LUN1_SEL;
	wire lun_bit = lun_q[0];
	wire data_phase = state == nand_lun_feat_pkg::ST_DATA;
	wire wr_hit = data_phase && is_set && i_cycle.wr && lun_ok;
	wire rd_hit = data_phase && !is_set && i_cycle.rd;
	wire byte_step = data_phase && (is_set ? i_cycle.wr : i_cycle.rd);

	// next phase: unit address strictly before feature address
	always_comb begin
		next_state = state;
		unique case (state)
			nand_lun_feat_pkg::ST_IDLE: begin
				if (is_get_cmd || is_set_cmd) next_state = nand_lun_feat_pkg::ST_LUN;
			end
			nand_lun_feat_pkg::ST_LUN: begin
				if (i_cycle.addr) next_state = nand_lun_feat_pkg::ST_FEAT;
			end
			nand_lun_feat_pkg::ST_FEAT: begin
				if (i_cycle.addr) next_state = nand_lun_feat_pkg::ST_DATA;
			end
			nand_lun_feat_pkg::ST_DATA: begin
				if (byte_step && idx == nand_lun_feat_pkg::BYTE3) next_state = nand_lun_feat_pkg::ST_IDLE;
			end
		endcase
		// a new get or set command restarts any access; any other command ends it
		if (i_cycle.cmd) next_state = (is_get_cmd || is_set_cmd) ? nand_lun_feat_pkg::ST_LUN : nand_lun_feat_pkg::ST_IDLE;
	end

	// phase register
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) state <= nand_lun_feat_pkg::ST_IDLE;
		else state <= next_state;
	end

	// direction, unit and feature latches
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			is_set <= 1'b0;
			lun_q <= 8'h00;
			feat_q <= 8'h00;
		end else begin
			if (i_cycle.cmd) is_set <= is_set_cmd;
			if (state == nand_lun_feat_pkg::ST_LUN && i_cycle.addr) lun_q <= i_cycle.value;
			if (state == nand_lun_feat_pkg::ST_FEAT && i_cycle.addr) feat_q <= i_cycle.value;
		end
	end

	// byte index, counting from byte 0 upward
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) idx <= nand_lun_feat_pkg::BYTE0;
		else if (state == nand_lun_feat_pkg::ST_FEAT) idx <= nand_lun_feat_pkg::BYTE0;
		else if (byte_step) idx <= idx + 2'h1;
	end

	// ----------------------------------------
	// writable fields
	// ----------------------------------------
	wire w_pin = wr_hit && feat_q == nand_lun_feat_pkg::FEAT_PIN_FUNC && idx == nand_lun_feat_pkg::BYTE3;
	wire w_duty = wr_hit && feat_q == nand_lun_feat_pkg::FEAT_DUTY && idx == nand_lun_feat_pkg::BYTE0;
	wire w_rx = wr_hit && feat_q == nand_lun_feat_pkg::FEAT_RX_TRAIN && idx == nand_lun_feat_pkg::BYTE0;

	// one field set per unit; reserved and read-only bits are dropped
	generate
		for (genvar l = 0; l < nand_lun_feat_pkg::LUN_COUNT; l++) begin : g_lun
			wire mine = lun_bit == 1'(l);
			always_ff @(posedge i_core_clk) begin
				if (!i_rst_n) cfg[l] <= nand_lun_feat_pkg::CFG_RST;
				else begin
					if (w_pin && mine) begin
						cfg[l].on_die_termination_function <= i_cycle.value[nand_lun_feat_pkg::PIN_FUNC_BIT];
					end
					if (w_duty && mine) begin
						cfg[l].explicit_duty_training_enable <= i_cycle.value[nand_lun_feat_pkg::EXPL_BIT];
						cfg[l].implicit_duty_training_enable <= i_cycle.value[nand_lun_feat_pkg::IMPL_BIT];
						cfg[l].duty_factory <= i_cycle.value[nand_lun_feat_pkg::DUTY_FACT_BIT]
							& nand_lun_feat_pkg::DUTY_FACTORY_SUP;
					end
					if (w_rx && mine) begin
						cfg[l].rx_factory <= i_cycle.value[nand_lun_feat_pkg::RX_FACT_BIT];
						cfg[l].every_unit_training_option <= i_cycle.value[nand_lun_feat_pkg::EVERY_BIT]
							& nand_lun_feat_pkg::EVERY_UNIT_SUP;
					end
				end
			end
			// training go request: addressed unit, or every-unit option set
			assign go_req[l] = i_train_start && (i_train_lun == 8'(l)
				|| cfg[l].every_unit_training_option);
			assign o_cfg[l] = cfg[l];
		end
	endgenerate

	// training go register, one process owns the whole vector
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) o_train_go <= 2'h0;
		else o_train_go <= go_req;
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	nand_lun_feat_pkg::lun_cfg_s rc;
	assign rc = cfg[lun_bit];
	wire [31:0] w05 = {1'b0, rc.on_die_termination_function, 6'h00, 24'h000000};
	wire [31:0] w20 = {8'h00, 3'h0, nand_lun_feat_pkg::RT_PAT_LONG, nand_lun_feat_pkg::WT_SIZE_CODE,
		8'h00, 5'h00, rc.duty_factory, rc.implicit_duty_training_enable, rc.explicit_duty_training_enable};
	wire [31:0] w21 = {8'h00, i_line_status[lun_bit],
		6'h00, rc.every_unit_training_option, rc.rx_factory};
	wire [31:0] rd_word = !lun_ok ? 32'h0 :
		feat_q == nand_lun_feat_pkg::FEAT_PIN_FUNC ? w05 :
		feat_q == nand_lun_feat_pkg::FEAT_DUTY ? w20 :
		feat_q == nand_lun_feat_pkg::FEAT_RX_TRAIN ? w21 : 32'h0;
	wire [7:0] rd_byte = rd_word[{idx, 3'b000} +: 8];

	// read data register, one byte per read strobe
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
			o_rdata_valid <= 1'b0;
		end else begin
			o_rdata_valid <= rd_hit;
			if (rd_hit) o_rdata <= rd_byte;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_cmd_taken;
		(is_get_cmd || is_set_cmd);
	endsequence
	sequence s_lun_taken;
		state == nand_lun_feat_pkg::ST_LUN && i_cycle.addr && !i_cycle.cmd;
	endsequence
	sequence s_feat_taken;
		state == nand_lun_feat_pkg::ST_FEAT && i_cycle.addr && !i_cycle.cmd;
	endsequence

	a_unit_first: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_cmd_taken ##1 s_lun_taken |=> state == nand_lun_feat_pkg::ST_FEAT && lun_q == $past(i_cycle.value))
		else $error("unit address not taken first");
	a_feat_second: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_feat_taken |=> data_phase && idx == nand_lun_feat_pkg::BYTE0 && feat_q == $past(i_cycle.value))
		else $error("feature address not taken second");
	a_unit_decode: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_train_start && i_train_lun == nand_lun_feat_pkg::LUN1_SEL |=> o_train_go[1])
		else $error("second unit not started");
	a_pin_func: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		w_pin && !lun_bit |=> o_cfg[0].on_die_termination_function == $past(i_cycle.value[6]))
		else $error("pin function not written");
	a_explicit_en: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		w_duty && lun_bit |=> o_cfg[1].explicit_duty_training_enable == $past(i_cycle.value[0]))
		else $error("explicit enable not written");
	a_implicit_en: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		w_duty && !lun_bit |=> o_cfg[0].implicit_duty_training_enable == $past(i_cycle.value[1]))
		else $error("implicit enable not written");
	a_duty_factory: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		w_duty && !lun_bit |=> o_cfg[0].duty_factory == $past(i_cycle.value[2]))
		else $error("factory duty select not written");
	a_size_code: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		rd_hit && lun_ok && feat_q == nand_lun_feat_pkg::FEAT_DUTY && idx == nand_lun_feat_pkg::BYTE2
		|=> o_rdata_valid && o_rdata == 8'h1f)
		else $error("training geometry byte wrong");
	a_rx_factory: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		w_rx && lun_bit |=> o_cfg[1].rx_factory == $past(i_cycle.value[0]))
		else $error("input path select not written");
	a_every_unit: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_train_start && o_cfg[0].every_unit_training_option |=> o_train_go[0])
		else $error("every-unit training not started");
	a_line_status: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		rd_hit && !lun_bit && lun_q[7:1] == 7'h00 && feat_q == nand_lun_feat_pkg::FEAT_RX_TRAIN
		&& idx == nand_lun_feat_pkg::BYTE1 |=> o_rdata == $past(i_line_status[0][7:0]))
		else $error("line status byte wrong");
	a_four_bytes: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_feat_taken ##1 (byte_step && !i_cycle.cmd)[*4] |=> state == nand_lun_feat_pkg::ST_IDLE)
		else $error("access not closed after four bytes");

	// ----------------------------------------
	// read path, hold, reset and training checks
	// ----------------------------------------
	// a data read by a valid unit selector
	sequence s_unit_rd;
		rd_hit && lun_ok;
	endsequence

	// reset leaves every output quiet
	a_reset_quiet: assert property (@(posedge i_core_clk)
		!i_rst_n |=> state == nand_lun_feat_pkg::ST_IDLE && !o_rdata_valid && o_train_go == 2'h0 && o_rdata == 8'h00)
		else $error("outputs not quiet after reset");

	// every taken read strobe answers next cycle
	a_valid_follows: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		rd_hit |=> o_rdata_valid)
		else $error("read strobe not answered");

	// no answer without a taken read strobe
	a_valid_only: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		!rd_hit |=> !o_rdata_valid)
		else $error("read answer without strobe");

	// an unknown unit selector reads as zero
	a_bad_unit_read: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		rd_hit && !lun_ok |=> o_rdata == 8'h00)
		else $error("unknown unit read not zero");

	// an unknown unit selector writes nothing
	a_bad_unit_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		data_phase && is_set && !lun_ok |=> $stable(o_cfg[0]) && $stable(o_cfg[1]))
		else $error("unknown unit write landed");

	// a read access never changes the fields
	a_get_no_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		data_phase && !is_set |=> $stable(o_cfg[0]) && $stable(o_cfg[1]))
		else $error("read access changed fields");

	// termination feature, bytes 0 to 2 reserved
	a_pin_reserved: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_unit_rd ##0 (feat_q == nand_lun_feat_pkg::FEAT_PIN_FUNC && idx != nand_lun_feat_pkg::BYTE3)
		|=> o_rdata == 8'h00)
		else $error("termination reserved byte not zero");

	// termination feature, byte 3 carries only bit 6
	a_pin_byte3: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_unit_rd ##0 (feat_q == nand_lun_feat_pkg::FEAT_PIN_FUNC && idx == nand_lun_feat_pkg::BYTE3)
		|=> o_rdata == {1'b0, $past(rc.on_die_termination_function), 6'h00})
		else $error("termination byte wrong");

	// second unit termination holds unless written
	a_pin_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		!(w_pin && lun_bit) |=> $stable(o_cfg[1].on_die_termination_function))
		else $error("termination changed unwritten");

	// duty byte 0 upper bits reserved
	a_duty_byte0: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_unit_rd ##0 (feat_q == nand_lun_feat_pkg::FEAT_DUTY && idx == nand_lun_feat_pkg::BYTE0)
		|=> o_rdata[7:3] == 5'h00)
		else $error("duty byte 0 reserved bits set");

	// duty bytes 1 and 3 reserved
	a_duty_reserved: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_unit_rd ##0 (feat_q == nand_lun_feat_pkg::FEAT_DUTY && idx[0])
		|=> o_rdata == 8'h00)
		else $error("duty reserved byte not zero");

	// first unit implicit enable holds unless written
	a_implicit_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		!(w_duty && !lun_bit) |=> $stable(o_cfg[0].implicit_duty_training_enable))
		else $error("implicit enable changed unwritten");

	// receive byte 0 upper bits reserved
	a_rx_byte0: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_unit_rd ##0 (feat_q == nand_lun_feat_pkg::FEAT_RX_TRAIN && idx == nand_lun_feat_pkg::BYTE0)
		|=> o_rdata[7:2] == 6'h00)
		else $error("receive byte 0 reserved bits set");

	// receive byte 3 reserved
	a_rx_byte3: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_unit_rd ##0 (feat_q == nand_lun_feat_pkg::FEAT_RX_TRAIN && idx == nand_lun_feat_pkg::BYTE3)
		|=> o_rdata == 8'h00)
		else $error("receive byte 3 not zero");

	// second unit, upper data line status
	a_status_high: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		s_unit_rd ##0 (lun_bit && feat_q == nand_lun_feat_pkg::FEAT_RX_TRAIN && idx == nand_lun_feat_pkg::BYTE2)
		|=> o_rdata == $past(i_line_status[1][15:8]))
		else $error("upper line status byte wrong");

	// first unit starts when addressed
	a_unit0_go: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		i_train_start && i_train_lun == nand_lun_feat_pkg::LUN0_SEL |=> o_train_go[0])
		else $error("first unit not started");

	// no training pulse without a request
	a_go_quiet: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		!i_train_start |=> o_train_go == 2'h0)
		else $error("training pulse without request");
endmodule : nand_per_lun_feature_regs

// ==== logic/nand_lun_feat_pkg.sv ====
// constants, types and state codes for the per-unit feature register bank
// assumes one core clock and host cycles already in that clock domain
package nand_lun_feat_pkg;
	// command opcodes opening a per-unit feature access
	localparam logic [7:0] CMD_GET_LUN = 8'h1a;
	localparam logic [7:0] CMD_SET_LUN = 8'h1b;
	// unit selector values
	localparam logic [7:0] LUN0_SEL = 8'h00;
	localparam logic [7:0] LUN1_SEL = 8'h01;
	localparam int LUN_COUNT = 2;
	// feature addresses
	localparam logic [7:0] FEAT_PIN_FUNC = 8'h05;
	localparam logic [7:0] FEAT_DUTY = 8'h20;
	localparam logic [7:0] FEAT_RX_TRAIN = 8'h21;
	// parameter byte indices and the last one
	localparam logic [1:0] BYTE0 = 2'h0;
	localparam logic [1:0] BYTE1 = 2'h1;
	localparam logic [1:0] BYTE2 = 2'h2;
	localparam logic [1:0] BYTE3 = 2'h3;
	// field bit positions
	localparam int PIN_FUNC_BIT = 6;
	localparam int EXPL_BIT = 0;
	localparam int IMPL_BIT = 1;
	localparam int DUTY_FACT_BIT = 2;
	localparam int RX_FACT_BIT = 0;
	localparam int EVERY_BIT = 1;
	// read-only training geometry and optional features
	localparam logic [3:0] WT_SIZE_CODE = 4'hf;
	localparam logic RT_PAT_LONG = 1'b1;
	localparam logic DUTY_FACTORY_SUP = 1'b1;
	localparam logic EVERY_UNIT_SUP = 1'b1;
	// per data line centering status codes
	localparam logic [1:0] CENTER_OK = 2'b00;
	localparam logic [1:0] CENTER_SLOW = 2'b01;
	localparam logic [1:0] CENTER_FAST = 2'b10;
	localparam logic [1:0] CENTER_UNKNOWN = 2'b11;
	// one host bus cycle
	typedef struct packed {
		logic cmd;
		logic addr;
		logic wr;
		logic rd;
		logic [7:0] value;
	} host_cycle_s;
	// per-unit configuration
	typedef struct packed {
		logic on_die_termination_function;
		logic explicit_duty_training_enable;
		logic implicit_duty_training_enable;
		logic duty_factory;
		logic rx_factory;
		logic every_unit_training_option;
	} lun_cfg_s;
	localparam lun_cfg_s CFG_RST = '0;
	typedef enum logic [1:0] {ST_IDLE, ST_LUN, ST_FEAT, ST_DATA} seq_state_e;
endpackage : nand_lun_feat_pkg

// ==== verification/nand_host_model.sv ====
// host controller model driving per-unit feature command, address and data cycles
// assumes the block samples its host cycle on the rising core clock edge
`timescale 1ns/10ps
module nand_host_model (
	input wire logic i_core_clk,
	input wire logic [7:0] i_rdata,
	input wire logic i_rdata_valid,
	output nand_lun_feat_pkg::host_cycle_s o_cycle
);
	// ----------------------------------------
	// read capture
	// ----------------------------------------
	logic [31:0] cap; // answered bytes, byte 0 lands lowest
	initial o_cycle = '0;
	// shift in each answered byte, byte 0 first
	always @(posedge i_core_clk) begin
		if (i_rdata_valid === 1'b1) begin
			cap <= {i_rdata, cap[31:8]};
		end
	end
	// ----------------------------------------
	// cycle tasks
	// ----------------------------------------
	// one bus cycle; kind is {cmd, addr, wr, rd}
	task automatic drive(input logic [3:0] kind, input logic [7:0] v);
		@(posedge i_core_clk);
		o_cycle <= {kind, v};
	endtask : drive
	// release the bus; the byte lines flip so no stale byte lingers
	task automatic idle();
		@(posedge i_core_clk);
		o_cycle <= {4'h0, ~o_cycle.value};
	endtask : idle
	// whole access: opcode, two address cycles, four data bytes
	task automatic access(input logic [7:0] op, input logic [7:0] first, input logic [7:0] second,
		input logic [31:0] word, output logic [31:0] got);
		drive(4'h8, op);
		drive(4'h4, first);
		drive(4'h4, second);
		for (int k = 0; k < 4; k++) begin
			drive((op == nand_lun_feat_pkg::CMD_SET_LUN) ? 4'h2 : 4'h1, word[8*k +: 8]);
		end
		idle();
		repeat (2) @(posedge i_core_clk);
		#1;
		got = cap;
	endtask : access
endmodule : nand_host_model

// ==== verification/nand_per_lun_feature_regs_tb.sv ====
// self-checking bench for the per-unit feature register bank
// assumes the host model file is compiled before this one
`timescale 1ns/10ps
module nand_per_lun_feature_regs_tb;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic core_clk; // 10 MHz core clock
	logic rst_n; // synchronous reset, active low
	nand_lun_feat_pkg::host_cycle_s cycle; // host bus cycle
	logic [15:0] line_status [nand_lun_feat_pkg::LUN_COUNT]; // per-unit centering codes
	logic train_start; // training request pulse
	logic [7:0] train_lun; // unit for training
	nand_lun_feat_pkg::lun_cfg_s cfg [nand_lun_feat_pkg::LUN_COUNT]; // per-unit fields
	logic [7:0] rdata; // read byte
	logic rdata_valid; // read byte strobe
	logic [1:0] train_go; // per-unit training pulse
	int n_fail; // mismatches
	int tests_run; // comparisons
	nand_per_lun_feature_regs dut_u (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_cycle(cycle),
		.i_line_status(line_status), .i_train_start(train_start), .i_train_lun(train_lun),
		.o_cfg(cfg), .o_rdata(rdata), .o_rdata_valid(rdata_valid), .o_train_go(train_go));
	nand_host_model host_u (.i_core_clk(core_clk), .i_rdata(rdata), .i_rdata_valid(rdata_valid),
		.o_cycle(cycle));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	// one comparison, counted
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// per-unit write
	task automatic setf(input logic [7:0] lun, input logic [7:0] feat, input logic [31:0] word);
		logic [31:0] unused;
		host_u.access(nand_lun_feat_pkg::CMD_SET_LUN, lun, feat, word, unused);
	endtask : setf
	// per-unit read compared with its expected word
	task automatic getf(input logic [7:0] lun, input logic [7:0] feat, input logic [31:0] exp);
		logic [31:0] got;
		host_u.access(nand_lun_feat_pkg::CMD_GET_LUN, lun, feat, 32'h0, got);
		chk("read word", exp, got);
	endtask : getf
	// configuration fields of one unit
	task automatic cfgchk(input int idx, input logic [5:0] exp);
		chk("cfg", {26'h0, exp}, {26'h0, cfg[idx]});
	endtask : cfgchk
	// training request and the pulse one cycle later
	task automatic train(input logic [7:0] lun, input logic [1:0] exp);
		@(posedge core_clk);
		train_start <= 1'b1;
		train_lun <= lun;
		@(posedge core_clk);
		train_start <= 1'b0;
		train_lun <= ~lun;
		#1;
		chk("train_go", {30'h0, exp}, {30'h0, train_go});
	endtask : train
	// verdict and end of run
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : complete_run
	// ----------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// cuts a hang short; tests need about 150 cycles
	initial begin
		#1000000;
		n_fail++;
		complete_run();
	end
	initial begin
		n_fail = 0;
		tests_run = 0;
		rst_n = 1'b0;
		train_start = 1'b0;
		train_lun = 8'h00;
		line_status[0] = 16'h55aa;
		line_status[1] = 16'h1be4;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		cfgchk(0, 6'h00);
		cfgchk(1, 6'h00);
		getf(8'h00, 8'h20, {8'h00, 3'h0, nand_lun_feat_pkg::RT_PAT_LONG, nand_lun_feat_pkg::WT_SIZE_CODE, 16'h0});
		$display("test reset done");
		setf(8'h01, 8'h05, 32'hffffffff);
		cfgchk(1, 6'h20);
		cfgchk(0, 6'h00);
		getf(8'h01, 8'h05, 32'h40000000);
		getf(8'h00, 8'h05, 32'h0);
		setf(8'h05, 8'h01, 32'h0);
		setf(8'h02, 8'h05, 32'h0);
		cfgchk(1, 6'h20);
		getf(8'h02, 8'h05, 32'h0);
		$display("test pin function done");
		setf(8'h00, 8'h20, 32'hffffffff);
		cfgchk(0, 6'h1c);
		getf(8'h00, 8'h20, {8'h00, 3'h0, nand_lun_feat_pkg::RT_PAT_LONG, nand_lun_feat_pkg::WT_SIZE_CODE, 16'h0007});
		setf(8'h00, 8'h20, 32'h00000001);
		cfgchk(0, 6'h10);
		$display("test duty done");
		setf(8'h01, 8'h21, 32'hffffffff);
		cfgchk(1, 6'h23);
		getf(8'h01, 8'h21, {8'h00, 16'h1be4, 8'h03});
		getf(8'h00, 8'h21, {8'h00, 16'h55aa, 8'h00});
		train(8'h00, 2'b11);
		setf(8'h01, 8'h21, 32'h0);
		train(8'h01, 2'b10);
		train(8'h00, 2'b01);
		$display("test training done");
		complete_run();
	end
endmodule : nand_per_lun_feature_regs_tb
